// File: rtl/clock_tree_pkg.sv
// constants, field layouts and helpers shared by the clock tree
// Overview of operation
// RULE_01: with the mode bit set the main oscillator is steered to lock at 23.986 MHz against a 32.768 kHz crystal.
// RULE_02: firmware drops the processor clock to 3 MHz or less, enables the mode, waits 10 ms, then speeds up.
// RULE_03: a new processor ratio takes effect with no settling delay beyond the current output period.
// RULE_04: the full rate clock is the undivided 48 MHz main oscillator.
// RULE_05: the half rate clock is the 24 MHz main oscillator output.
// RULE_06: the first divided clock is the half rate clock divided by N+1, N from control one bits 7:4.
// RULE_07: the second divided clock is the first divided clock divided by M+1, M from control one bits 3:0.
// RULE_08: the low speed mux carries the internal oscillator when bit 7 of control zero is 0, else the crystal.
// RULE_09: the processor clock is the main oscillator divided by one of eight ratios from 1:1 to 1:256.
// RULE_10: the sleep clock is the low speed mux clock divided to 512, 64, 8 or 1 Hz by bits 4:3.
// RULE_11: a processor ratio change touches no other selection and makes no glitch or runt pulse.
// RULE_12: a new crystal select waits for the end of the current sleep interval before the mux switches.
// RULE_13: firmware lets the crystal settle for a full interval before enabling the lock mode.
// RULE_14: a divider field change applies at that divider's next output period boundary.
// RULE_15: reserved bit 5 of control zero reads zero and writes to it do nothing.
package clock_tree_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] CTRL0_INDEX = 8'hE0;
    localparam logic [7:0] CTRL1_INDEX = 8'hE1;
    localparam logic [7:0] TRIM_INDEX  = 8'hEB;
    localparam int         ADDR_W      = 12;

    // reset values; the trim value stands in for a factory value
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] TRIM_RESET  = 8'h00;
    localparam logic [7:0] TRIM_WMASK  = 8'hCF;
    localparam logic [7:0] CTRL0_WMASK = 8'hDF;

    // field positions
    localparam int XSEL_BIT   = 7;
    localparam int PLL_BIT    = 6;
    localparam int RSVD_BIT   = 5;
    localparam int SLEEP_LSB  = 3;
    localparam int CPU_LSB    = 0;
    localparam int FIRST_LSB  = 4;
    localparam int SECOND_LSB = 0;

    // lock target: main oscillator edges per crystal period
    localparam int PLL_FREQ_HZ  = 23986000;
    localparam int XTAL_FREQ_HZ = 32768;
    localparam int PLL_TARGET   = (2 * PLL_FREQ_HZ + XTAL_FREQ_HZ / 2) / XTAL_FREQ_HZ;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       crystal_select;
        logic       pll_mode;
        logic       reserved;
        logic [1:0] sleep_period;
        logic [2:0] cpu_ratio;
    } ctrl0_s;

    typedef struct packed {
        logic [3:0] first_div;
        logic [3:0] second_div;
    } ctrl1_s;

    // ratio minus one for each processor clock code
    function automatic logic [7:0] cpu_limit(input logic [2:0] code);
        case (code)
            3'h0:    cpu_limit = 8'h07;
            3'h1:    cpu_limit = 8'h03;
            3'h2:    cpu_limit = 8'h01;
            3'h3:    cpu_limit = 8'h00;
            3'h4:    cpu_limit = 8'h0F;
            3'h5:    cpu_limit = 8'h1F;
            3'h6:    cpu_limit = 8'h7F;
            default: cpu_limit = 8'hFF;
        endcase
    endfunction

    // sleep divide is two to the power 6, 9, 12 or 15
    function automatic logic [3:0] sleep_shift(input logic [1:0] code);
        sleep_shift = 4'h6 + 4'(code) * 4'h3;
    endfunction

endpackage

// File: rtl/clock_divider.sv
// integer clock divider driven by source edge pulses
module clock_divider #(
    parameter int         W           = 4,
    parameter logic [W-1:0] RESET_LIMIT = '0
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         edge_tick,
    input  wire logic [W-1:0] limit,
    output logic              clk_out,
    output logic              edge_out
);

    logic [W-1:0] cur_limit;
    logic [W-1:0] cnt;
    logic         wrap;

    assign wrap = edge_tick && (cnt == cur_limit);

    ////////////////////////////////////////////////////////////////////////
    // toggle every limit+1 source edges: period is twice limit+1 source periods
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt       <= '0;
            clk_out   <= 1'b0;
            cur_limit <= RESET_LIMIT;
            edge_out  <= 1'b0;
        end else begin
            edge_out <= wrap;
            if (wrap) begin
                cnt     <= '0;
                clk_out <= ~clk_out;
                // load only as a new period opens, so no runt pulse (see RULE_14) (see RULE_11)
                if (!clk_out)
                    cur_limit <= limit;
            end else if (edge_tick) begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_limit_at_boundary;
        @(posedge aclk) disable iff (!aresetn)
        (cur_limit != $past(cur_limit)) |-> (clk_out && !$past(clk_out));
    endproperty
    a_limit_at_boundary: assert property (p_limit_at_boundary) // see RULE_14
        else $error("divider ratio changed inside a period");

    property p_count_bound;
        @(posedge aclk) disable iff (!aresetn)
        edge_tick && (cnt != cur_limit) |=> (clk_out == $past(clk_out)) && (cnt == $past(cnt) + 1'b1);
    endproperty
    a_count_bound: assert property (p_count_bound) // see RULE_06
        else $error("divider toggled before its count");

endmodule

// File: rtl/system_clock_tree.sv
// system clock generation, division and selection with its registers
module system_clock_tree (
    input  wire logic                              aclk,
    input  wire logic                              aresetn,
    input  wire logic [clock_tree_pkg::ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                        awprot,
    input  wire logic                              awvalid,
    output logic                                   awready,
    input  wire logic [31:0]                       wdata,
    input  wire logic [3:0]                        wstrb,
    input  wire logic                              wvalid,
    output logic                                   wready,
    output logic [1:0]                             bresp,
    output logic                                   bvalid,
    input  wire logic                              bready,
    input  wire logic [clock_tree_pkg::ADDR_W-1:0] araddr,
    input  wire logic [2:0]                        arprot,
    input  wire logic                              arvalid,
    output logic                                   arready,
    output logic [31:0]                            rdata,
    output logic [1:0]                             rresp,
    output logic                                   rvalid,
    input  wire logic                              rready,
    input  wire logic                              main_osc_in,
    input  wire logic                              low_speed_osc_in,
    input  wire logic                              crystal_osc_in,
    output logic                                   main_osc_full_rate_clock,
    output logic                                   main_osc_half_rate_clock,
    output logic                                   first_divided_clock,
    output logic                                   second_divided_clock,
    output logic                                   processor_clock,
    output logic                                   low_speed_mux_clock,
    output logic                                   sleep_timer_clock,
    output logic                                   sleep_interval_end,
    output logic                                   crystal_active,
    output logic                                   pll_enable,
    output logic                                   pll_speed_up,
    output logic                                   pll_slow_down,
    output logic [7:0]                             crystal_trim_value
);

    clock_tree_pkg::ctrl0_s ctrl0;
    clock_tree_pkg::ctrl1_s ctrl1;
    logic [7:0]             trim;
    logic                   aw_held;
    logic                   w_held;
    logic [1:0]             wsel;
    logic [7:0]             wbyte;
    logic                   wlane;
    logic                   wr_fire;
    logic [2:0]             imo_q;
    logic [2:0]             ilo_q;
    logic [2:0]             eco_q;
    logic                   imo_rise;
    logic                   ilo_rise;
    logic                   eco_rise;
    logic                   lsm_rise;
    logic [14:0]            slp_cnt;
    logic [3:0]             shift;
    logic [14:0]            slp_mask;
    logic                   interval_end;
    logic [11:0]            pll_cnt;
    logic                   pll_run;
    logic                   v1_edge;

    ////////////////////////////////////////////////////////////////////////
    // address decode, shared by both channels; 3 means unmapped
    function automatic logic [1:0] reg_sel(input logic [clock_tree_pkg::ADDR_W-1:0] a);
        if (a[1:0] != 2'h0)
            reg_sel = 2'h3;
        else if (a[9:2] == clock_tree_pkg::CTRL0_INDEX && a[11:10] == 2'h0)
            reg_sel = 2'h0;
        else if (a[9:2] == clock_tree_pkg::CTRL1_INDEX && a[11:10] == 2'h0)
            reg_sel = 2'h1;
        else if (a[9:2] == clock_tree_pkg::TRIM_INDEX && a[11:10] == 2'h0)
            reg_sel = 2'h2;
        else
            reg_sel = 2'h3;
    endfunction

    // read value of a register; reserved bits come back zero
    function automatic logic [7:0] reg_value(input logic [1:0] s,
                                            input logic [7:0] c0,
                                            input logic [7:0] c1,
                                            input logic [7:0] t);
        case (s)
            2'h0:    reg_value = c0 & clock_tree_pkg::CTRL0_WMASK; // see RULE_15
            2'h1:    reg_value = c1;
            2'h2:    reg_value = t & clock_tree_pkg::TRIM_WMASK;
            default: reg_value = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write address and data are taken in either order, one write at a time
    assign wr_fire = aw_held && w_held && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            wsel    <= 2'h3;
            wbyte   <= 8'h00;
            wlane   <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= clock_tree_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                awready <= 1'b0;
                wsel    <= reg_sel(awaddr);
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wready <= 1'b0;
                wbyte  <= wdata[7:0];
                wlane  <= wstrb[0];
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= (wsel == 2'h3) ? clock_tree_pkg::RESP_SLVERR : clock_tree_pkg::RESP_OKAY;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register storage; only byte lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl0 <= clock_tree_pkg::CTRL0_RESET;
            ctrl1 <= clock_tree_pkg::CTRL1_RESET;
            trim  <= clock_tree_pkg::TRIM_RESET;
        end else if (wr_fire && wlane) begin
            case (wsel)
                2'h0:    ctrl0 <= wbyte & clock_tree_pkg::CTRL0_WMASK; // see RULE_15
                2'h1:    ctrl1 <= wbyte;
                2'h2:    trim  <= wbyte & clock_tree_pkg::TRIM_WMASK;
                default: ctrl1 <= ctrl1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel answers one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= clock_tree_pkg::RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= {24'h00_0000, reg_value(reg_sel(araddr), ctrl0, ctrl1, trim)};
                rresp   <= (reg_sel(araddr) == 2'h3) ? clock_tree_pkg::RESP_SLVERR
                                                     : clock_tree_pkg::RESP_OKAY;
            end
            if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator pins are asynchronous: two flops, then a third for edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            imo_q <= 3'h0;
            ilo_q <= 3'h0;
            eco_q <= 3'h0;
        end else begin
            imo_q <= {imo_q[1:0], main_osc_in};
            ilo_q <= {ilo_q[1:0], low_speed_osc_in};
            eco_q <= {eco_q[1:0], crystal_osc_in};
        end
    end

    assign imo_rise = imo_q[1] && !imo_q[2];
    assign ilo_rise = ilo_q[1] && !ilo_q[2];
    assign eco_rise = eco_q[1] && !eco_q[2];

    ////////////////////////////////////////////////////////////////////////
    // full rate is the oscillator itself, half rate toggles on its rise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_osc_full_rate_clock <= 1'b0;
            main_osc_half_rate_clock <= 1'b0;
        end else begin
            main_osc_full_rate_clock <= imo_q[1]; // see RULE_04
            if (imo_rise)
                main_osc_half_rate_clock <= ~main_osc_half_rate_clock; // see RULE_05
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // each half rate edge is one main oscillator rise; the first and processor dividers count those
    clock_divider #(
        .W           (4),
        .RESET_LIMIT (4'h0)
    ) u_first_div (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .edge_tick (imo_rise),
        .limit     (ctrl1.first_div), // see RULE_06
        .clk_out   (first_divided_clock),
        .edge_out  (v1_edge)
    );

    // chained off the first divider's edges
    clock_divider #(
        .W           (4),
        .RESET_LIMIT (4'h0)
    ) u_second_div (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .edge_tick (v1_edge),
        .limit     (ctrl1.second_div), // see RULE_07
        .clk_out   (second_divided_clock),
        .edge_out  ()
    );

    // own divider, so a ratio write disturbs nothing else
    clock_divider #(
        .W           (8),
        .RESET_LIMIT (8'h07)
    ) u_cpu_div (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .edge_tick (imo_rise),
        .limit     (clock_tree_pkg::cpu_limit(ctrl0.cpu_ratio)), // see RULE_09 (see RULE_03) (see RULE_11)
        .clk_out   (processor_clock),
        .edge_out  ()
    );

    ////////////////////////////////////////////////////////////////////////
    // low speed mux; the applied select only moves at an interval end
    assign lsm_rise = crystal_active ? eco_rise : ilo_rise; // see RULE_08
    assign shift    = clock_tree_pkg::sleep_shift(ctrl0.sleep_period);
    assign slp_mask = 15'((16'h0001 << shift) - 16'h0001);
    assign interval_end = lsm_rise && ((slp_cnt & slp_mask) == slp_mask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crystal_active      <= 1'b0;
            low_speed_mux_clock <= 1'b0;
        end else begin
            low_speed_mux_clock <= crystal_active ? eco_q[1] : ilo_q[1]; // see RULE_08
            // the crystal is switched in at the end of the current interval, however little of it is left
            if (interval_end)
                crystal_active <= ctrl0.crystal_select; // see RULE_12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sleep prescaler: one bit of a ripple count per period choice
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slp_cnt            <= 15'h0000;
            sleep_timer_clock  <= 1'b0;
            sleep_interval_end <= 1'b0;
        end else begin
            if (lsm_rise)
                slp_cnt <= slp_cnt + 15'h0001;
            sleep_timer_clock  <= slp_cnt[shift - 4'h1]; // see RULE_10
            sleep_interval_end <= interval_end;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock detector: count oscillator rises across one crystal period
    // and tell the analog loop which way to steer; trim stays analog
    assign pll_run = ctrl0.pll_mode && crystal_active;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pll_cnt       <= 12'h000;
            pll_speed_up  <= 1'b0;
            pll_slow_down <= 1'b0;
            pll_enable    <= 1'b0;
        end else begin
            pll_enable <= ctrl0.pll_mode;
            if (!pll_run) begin
                pll_cnt       <= 12'h000;
                pll_speed_up  <= 1'b0;
                pll_slow_down <= 1'b0;
            end else if (eco_rise) begin
                pll_cnt       <= {11'h000, imo_rise};
                pll_speed_up  <= pll_cnt < 12'(clock_tree_pkg::PLL_TARGET); // see RULE_01
                pll_slow_down <= pll_cnt > 12'(clock_tree_pkg::PLL_TARGET);
            end else if (imo_rise && pll_cnt != 12'hFFF) begin
                pll_cnt <= pll_cnt + 12'h001; // saturates when far off lock
            end
        end
    end

    // trim is passed to the analog crystal amplifier
    always_ff @(posedge aclk) begin
        if (!aresetn)
            crystal_trim_value <= clock_tree_pkg::TRIM_RESET;
        else
            crystal_trim_value <= trim & clock_tree_pkg::TRIM_WMASK;
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_osc_rise;
        imo_q[1] && !imo_q[2];
    endsequence

    sequence s_half_moved;
        main_osc_half_rate_clock != $past(main_osc_half_rate_clock);
    endsequence

    property p_half_rate;
        @(posedge aclk) disable iff (!aresetn)
        s_osc_rise |=> s_half_moved;
    endproperty
    a_half_rate: assert property (p_half_rate) // see RULE_05
        else $error("half rate clock missed an oscillator rise");

    property p_full_rate;
        @(posedge aclk) disable iff (!aresetn)
        s_osc_rise |=> main_osc_full_rate_clock ##1 (main_osc_full_rate_clock == $past(imo_q[1]));
    endproperty
    a_full_rate: assert property (p_full_rate) // see RULE_04
        else $error("full rate clock does not follow the oscillator");

    property p_switch_at_end;
        @(posedge aclk) disable iff (!aresetn)
        (crystal_active != $past(crystal_active)) |-> sleep_interval_end;
    endproperty
    a_switch_at_end: assert property (p_switch_at_end) // see RULE_12
        else $error("mux source changed away from an interval end");

    property p_reserved_read;
        @(posedge aclk) disable iff (!aresetn)
        (arvalid && arready && reg_sel(araddr) == 2'h0) |=> rvalid && !rdata[clock_tree_pkg::RSVD_BIT];
    endproperty
    a_reserved_read: assert property (p_reserved_read) // see RULE_15
        else $error("reserved bit read back as one");

    property p_lock_idle;
        @(posedge aclk) disable iff (!aresetn)
        !ctrl0.pll_mode |=> !pll_speed_up && !pll_slow_down && pll_cnt == 12'h000;
    endproperty
    a_lock_idle: assert property (p_lock_idle) // see RULE_01
        else $error("lock steering active with the mode off");

    property p_sleep_tap;
        @(posedge aclk) disable iff (!aresetn)
        $stable(shift) |=> sleep_timer_clock == $past(slp_cnt[shift - 4'h1]);
    endproperty
    a_sleep_tap: assert property (p_sleep_tap) // see RULE_10
        else $error("sleep clock taken from the wrong prescaler tap");

    property p_write_answer;
        @(posedge aclk) disable iff (!aresetn)
        (awvalid && awready && wvalid && wready) |-> ##[1:2] bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write response late");

endmodule

// File: sim/system_clock_tree_bench.sv
// self-checking bench for the clock tree and its register bus
module system_clock_tree_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [2:0]  awprot = 0, arprot = 0;
    logic [3:0]  wstrb = 4'hF;
    logic        main_osc_in = 0, low_speed_osc_in = 0, crystal_osc_in = 0;
    logic        awready, wready, bvalid, arready, rvalid, sleep_interval_end, crystal_active, pll_enable;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  crystal_trim_value;
    logic        main_osc_full_rate_clock, main_osc_half_rate_clock, first_divided_clock;
    logic        second_divided_clock, processor_clock, low_speed_mux_clock, sleep_timer_clock;
    logic        pll_speed_up, pll_slow_down;
    int          failures = 0, n_tests = 0;
    wire  [6:0]  clks = {low_speed_mux_clock, sleep_timer_clock, processor_clock, second_divided_clock,
                         first_divided_clock, main_osc_half_rate_clock, main_osc_full_rate_clock};
    system_clock_tree system_clock_tree_inst (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .main_osc_in, .low_speed_osc_in, .crystal_osc_in, .main_osc_full_rate_clock,
        .main_osc_half_rate_clock, .first_divided_clock, .second_divided_clock, .processor_clock,
        .low_speed_mux_clock, .sleep_timer_clock, .sleep_interval_end, .crystal_active, .pll_enable,
        .pll_speed_up, .pll_slow_down, .crystal_trim_value);
    ////////////////////////////////////////////////////////////////////////
    // clocks; oscillator periods are whole aclk counts so periods come out exact
    initial begin
        forever #2.5 aclk = ~aclk;
    end
    always #20 main_osc_in = ~main_osc_in;       // 8 aclk period
    always #40 low_speed_osc_in = ~low_speed_osc_in; // 16 aclk period
    always #30 crystal_osc_in = ~crystal_osc_in; // 12 aclk period
    ////////////////////////////////////////////////////////////////////////
    task complete_run;
        if (failures == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task hang;
        failures++;
        $display("mismatch at %0t: wait ran out", $time);
        complete_run();
    endtask
    // bus master: holds each channel until its ready, waits for the answer under a bound
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) break;
        end
        bready <= 0;
        if (i == 40) hang();
        chk(bresp, r);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid) break;
        end
        rready <= 0;
        if (i == 40) hang();
        chk(rdata, e);
        chk(rresp, r);
    endtask
    // period of clock k in aclk cycles; the first periods are skipped so a pending ratio settles
    task per(input int k, input int e);
        int i, n, t0;
        logic p;
        n = 0;
        p = clks[k];
        for (i = 0; i < 30000 && n < 4; i++) begin
            @(posedge aclk);
            if (clks[k] && !p) n++;
            if (clks[k] && !p && n == 3) t0 = i;
            p = clks[k];
        end
        if (n < 4) hang();
        chk(i - 1 - t0, e); // loop index has already stepped past the fourth rise
    endtask
    ////////////////////////////////////////////////////////////////////////
    task s_regs;
        rd(12'h380, 0, 0);
        rd(12'h384, 0, 0);
        rd(12'hC00, 0, 2);
        wr(12'hC00, 32'hFF, 2);
        wr(12'h380, 32'h20, 0);
        rd(12'h380, 0, 0);
        wr(12'h3AC, 32'hFF, 0);
        rd(12'h3AC, 32'hCF, 0);
        chk(crystal_trim_value, 8'hCF);
    endtask
    task s_div;
        wr(12'h384, 32'h21, 0);
        per(0, 8);
        per(1, 16);
        per(2, 48);
        per(3, 96);
    endtask
    // every processor ratio code; the first divider must stay put meanwhile
    task s_cpu;
        int ratio[8] = '{8, 4, 2, 1, 16, 32, 128, 256};
        for (int c = 0; c < 8; c++) begin
            wr(12'h380, c, 0);
            per(4, ratio[c] * 16);
        end
        per(2, 48);
    endtask
    task s_xtal;
        int i;
        per(6, 16);
        wr(12'h380, 32'h80, 0);
        for (i = 0; i < 3000 && !sleep_interval_end; i++) begin
            @(posedge aclk);
            if (!sleep_interval_end) chk(crystal_active, 0);
        end
        if (i == 3000) hang();
        chk(crystal_active, 1);
        per(6, 12);
        per(5, 768);
        // processor stays at 3 MHz and the crystal has had its interval before the lock mode goes on
        wr(12'h380, 32'hC8, 0);
        @(posedge aclk);
        chk(pll_enable, 1);
        per(5, 6144);
        // the bench oscillator is far too slow for lock, so the loop must be told to speed up
        chk(pll_speed_up, 1);
        chk(pll_slow_down, 0);
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        s_regs();
        s_div();
        s_cpu();
        s_xtal();
        complete_run();
    end
endmodule
